//--- common/rps_pkg.sv
// Package for the ramp phase and spread-spectrum control block.
// Assumes one 100 MHz clock standing in for the PLL clock domain.
package rps_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_PHASE = 8'h6a;
  localparam logic [7:0] ADDR_DITHER = 8'h6b;
  localparam logic [7:0] ADDR_RANGE = 8'h6c;
  localparam logic [7:0] ADDR_DIV = 8'h6d;
  localparam logic [7:0] ADDR_STEP = 8'h6e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_DITHER = 8'h00;
  localparam logic [7:0] RST_RANGE = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h50;
  localparam logic [7:0] RST_STEP = 8'h11;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PH_SYNC_BIT = 0;
  localparam int I2S_SYNC_BIT = 1;
  localparam int PH_SEL_LSB = 2;
  localparam int PH_SEL_W = 2;
  localparam int TRI_EN_BIT = 0;
  localparam int RDM_EN_BIT = 1;
  localparam int MANUAL_BIT = 4;
  localparam int HALF_SRC_BIT = 5;
  localparam int TRI_CTRL_LSB = 0;
  localparam int TRI_CTRL_W = 4;
  localparam int RDM_SPAN_LSB = 4;
  localparam int RDM_SPAN_W = 3;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 4;
  localparam int STEP_W = 4;

  // ****************************************
  // Ramp timing
  // ****************************************
  localparam int REF_HZ = 61440000;
  localparam int CLK_HZ = 100000000;
  localparam int CNT_W = 10;
  localparam logic [7:0] AUTO_DIV = 8'h50;
  localparam logic [7:0] TRI_MAN_LIMIT = 8'h10;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

endpackage : rps_pkg

//--- logic/rps_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
// Assumes the pin is asynchronous to clock.
module rps_pin_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pin and result
  input wire logic pin,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } rps_sync_state_t;

  rps_sync_state_t state_r;
  rps_sync_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.s1 = pin;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    state_nxt.rise = 1'b0;
    // Only a level seen by two later stages counts
    if (state_r.s2 == state_r.s3) begin
      state_nxt.lvl = state_r.s3;
      state_nxt.rise = state_r.s3 & ~state_r.lvl;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign level = state_r.lvl;
  assign rise = state_r.rise;

endmodule : rps_pin_sync

//--- logic/rps_lfsr.sv
// Galois LFSR used as the random dither source.
// Assumes the enable is a one-cycle pulse on the same clock.
module rps_lfsr (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control and value
  input wire logic step,
  output logic [15:0] value
);

  typedef struct packed {
    logic [15:0] sr;
  } rps_lfsr_state_t;

  rps_lfsr_state_t state_r;
  rps_lfsr_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (step) begin
      state_nxt.sr = {1'b0, state_r.sr[15:1]} ^ (state_r.sr[0] ? rps_pkg::LFSR_TAPS : 16'h0000);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r.sr <= rps_pkg::LFSR_SEED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign value = state_r.sr;

endmodule : rps_lfsr

//--- logic/rps_ramp_ctrl.sv
// Ramp clock phase selection and spread-spectrum dither control.
// Assumes clock is the PLL clock and the register port is on the same clock.
// Functional notes
// RULE_01: Phase select bits 3-2 shift ramp phase
// RULE_02: Software sets phase before entering play
// RULE_03: All devices share ramp and dither settings
// RULE_04: I2S sync bit aligns ramp to framing
// RULE_05: Phase sync bit enables external ramp sync
// RULE_06: Manual halved-source bit halves the source clock
// RULE_07: Manual bit selects manual dither control
// RULE_08: Random dither spans range field bits 6-4
// RULE_09: Triangle dither uses field bits 3-0; the code uses them in automatic mode only, manual mode uses TRI_MAN_LIMIT
// RULE_10: Manual ramp period equals divisor N
// RULE_11: Falling slope steps by bits 7-4
// RULE_12: Rising slope steps by bits 3-0
// RULE_13: Automatic mode ignores all manual fields
module rps_ramp_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sync pins
  input wire logic i2s_frame_pin,
  input wire logic ramp_sync_pin,
  // Ramp outputs
  output logic ramp_tick,
  output logic [9:0] ramp_period
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] ramp_phase_setup;
    logic [7:0] dither_control;
    logic [7:0] dither_range;
    logic [7:0] manual_ramp_divider;
    logic [7:0] triangle_step_sizes;
    logic [7:0] rdata;
    logic half_ph;
    logic [9:0] cnt;
    logic [9:0] period;
    logic [7:0] tri_off;
    logic tri_down;
    logic tick;
  } rps_ctrl_state_t;

  rps_ctrl_state_t state_r;
  rps_ctrl_state_t state_nxt;

  logic frame_rise;
  logic sync_rise;
  logic [15:0] lfsr_val;
  logic wrap;
  logic src_en;
  logic restart;
  logic manual;
  logic half_src;
  logic tri_en;
  logic rdm_en;
  logic i2s_en;
  logic ph_en;
  logic [1:0] phase_sel;
  logic [7:0] base;
  logic [7:0] limit;
  logic [7:0] rise_step;
  logic [7:0] fall_step;
  logic [7:0] span_mask;
  logic [7:0] rdm_off;
  logic [7:0] tri_new;
  logic [9:0] phase_off;
  logic [8:0] tri_up_sum;

  rps_pin_sync u_frame_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(i2s_frame_pin),
    .level(),
    .rise(frame_rise)
  );

  rps_pin_sync u_ramp_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(ramp_sync_pin),
    .level(),
    .rise(sync_rise)
  );

  rps_lfsr u_lfsr (
    .clock(clock),
    .rst_n(rst_n),
    .step(wrap),
    .value(lfsr_val)
  );

  // ****************************************
  // Field decode
  // ****************************************
  assign ph_en = state_r.ramp_phase_setup[rps_pkg::PH_SYNC_BIT];
  assign i2s_en = state_r.ramp_phase_setup[rps_pkg::I2S_SYNC_BIT];
  assign phase_sel = state_r.ramp_phase_setup[rps_pkg::PH_SEL_LSB +: rps_pkg::PH_SEL_W];
  assign tri_en = state_r.dither_control[rps_pkg::TRI_EN_BIT];
  assign rdm_en = state_r.dither_control[rps_pkg::RDM_EN_BIT];
  assign manual = state_r.dither_control[rps_pkg::MANUAL_BIT]; // [RULE_07]
  // Halving only counts in manual mode
  assign half_src = manual & state_r.dither_control[rps_pkg::HALF_SRC_BIT]; // [RULE_06] [RULE_13]

  // A zero divisor with no dither would only wrap after 1024 counts, so it is treated as one
  always_comb begin
    if (!manual) begin
      base = rps_pkg::AUTO_DIV; // [RULE_13]
    end else if (state_r.manual_ramp_divider == 8'h00) begin
      base = 8'h01;
    end else begin
      base = state_r.manual_ramp_divider; // [RULE_10]
    end
  end

  always_comb begin
    if (manual) begin
      limit = rps_pkg::TRI_MAN_LIMIT;
      rise_step = {4'h0, state_r.triangle_step_sizes[rps_pkg::RISE_LSB +: rps_pkg::STEP_W]}; // [RULE_12]
      fall_step = {4'h0, state_r.triangle_step_sizes[rps_pkg::FALL_LSB +: rps_pkg::STEP_W]}; // [RULE_11]
    end else begin
      limit = {4'h0, state_r.dither_range[rps_pkg::TRI_CTRL_LSB +: rps_pkg::TRI_CTRL_W]}; // [RULE_09]
      rise_step = 8'h01; // [RULE_13]
      fall_step = 8'h01;
    end
  end

  assign span_mask = (8'h01 << state_r.dither_range[rps_pkg::RDM_SPAN_LSB +: rps_pkg::RDM_SPAN_W]) - 8'h01;
  assign rdm_off = rdm_en ? (lfsr_val[7:0] & span_mask) : 8'h00; // [RULE_08]
  assign tri_up_sum = {1'b0, state_r.tri_off} + {1'b0, fall_step};

  // ****************************************
  // Triangle sweep
  // ****************************************
  // Growing offset lengthens the period, so the frequency falls
  always_comb begin
    tri_new = state_r.tri_off;
    if (!tri_en) begin
      tri_new = 8'h00;
    end else if (!state_r.tri_down) begin
      tri_new = (tri_up_sum >= {1'b0, limit}) ? limit : tri_up_sum[7:0]; // [RULE_11]
    end else begin
      tri_new = (state_r.tri_off <= rise_step) ? 8'h00 : state_r.tri_off - rise_step; // [RULE_12]
    end
    // A limit lowered mid-sweep would otherwise leave the offset above it
    if (tri_new > limit) begin
      tri_new = limit; // [RULE_09]
    end
  end

  // ****************************************
  // Ramp counter
  // ****************************************
  assign src_en = ~half_src | state_r.half_ph; // [RULE_06]
  assign restart = (i2s_en & frame_rise) | (ph_en & sync_rise); // [RULE_04] [RULE_05]
  assign wrap = ~restart & src_en & (state_r.cnt >= state_r.period - 10'd1);
  assign phase_off = 10'({2'b00, state_r.period[9:2]} * {8'h00, phase_sel}); // [RULE_01]

  always_comb begin
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    state_nxt.half_ph = half_src ? ~state_r.half_ph : 1'b0;
    if (reg_wr_en) begin
      case (reg_addr)
        rps_pkg::ADDR_PHASE: state_nxt.ramp_phase_setup = reg_wdata;
        rps_pkg::ADDR_DITHER: state_nxt.dither_control = reg_wdata;
        rps_pkg::ADDR_RANGE: state_nxt.dither_range = reg_wdata;
        rps_pkg::ADDR_DIV: state_nxt.manual_ramp_divider = reg_wdata;
        rps_pkg::ADDR_STEP: state_nxt.triangle_step_sizes = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd_en) begin
      case (reg_addr)
        rps_pkg::ADDR_PHASE: state_nxt.rdata = state_r.ramp_phase_setup;
        rps_pkg::ADDR_DITHER: state_nxt.rdata = state_r.dither_control;
        rps_pkg::ADDR_RANGE: state_nxt.rdata = state_r.dither_range;
        rps_pkg::ADDR_DIV: state_nxt.rdata = state_r.manual_ramp_divider;
        rps_pkg::ADDR_STEP: state_nxt.rdata = state_r.triangle_step_sizes;
        default: state_nxt.rdata = 8'h00;
      endcase
    end
    if (restart) begin
      state_nxt.cnt = '0; // [RULE_04] [RULE_05]
    end else if (wrap) begin
      state_nxt.cnt = '0;
      state_nxt.tri_off = tri_new; // [RULE_09]
      if (!tri_en) begin
        state_nxt.tri_down = 1'b0;
      end else if (!state_r.tri_down && tri_up_sum >= {1'b0, limit}) begin
        state_nxt.tri_down = 1'b1;
      end else if (state_r.tri_down && state_r.tri_off <= rise_step) begin
        state_nxt.tri_down = 1'b0;
      end
      // New period takes effect at the wrap only, so a ramp is never cut short
      state_nxt.period = {2'b00, base} + {2'b00, tri_new} + {2'b00, rdm_off}; // [RULE_08] [RULE_10]
    end else if (src_en) begin
      state_nxt.cnt = state_r.cnt + 10'd1;
    end
    if (src_en && !restart && state_r.cnt == phase_off) begin
      state_nxt.tick = 1'b1; // [RULE_01]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.ramp_phase_setup <= rps_pkg::RST_PHASE;
      state_r.dither_control <= rps_pkg::RST_DITHER;
      state_r.dither_range <= rps_pkg::RST_RANGE;
      state_r.manual_ramp_divider <= rps_pkg::RST_DIV;
      state_r.triangle_step_sizes <= rps_pkg::RST_STEP;
      state_r.period <= {2'b00, rps_pkg::AUTO_DIV};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign ramp_tick = state_r.tick;
  assign ramp_period = state_r.period;

  // ****************************************
  // Assertions
  // ****************************************
  property p_tick_phase;
    @(posedge clock) disable iff (!rst_n)
    ramp_tick |-> $past(state_r.cnt) == $past(phase_off);
  endproperty
  a_tick_phase: assert property (p_tick_phase) else $error("tick off phase"); // [RULE_01]

  property p_i2s_align;
    @(posedge clock) disable iff (!rst_n)
    (i2s_en && frame_rise) |=> state_r.cnt == 10'd0;
  endproperty
  a_i2s_align: assert property (p_i2s_align) else $error("no frame align"); // [RULE_04]

  property p_no_sync;
    @(posedge clock) disable iff (!rst_n)
    (!i2s_en && !ph_en && state_r.cnt < state_r.period - 10'd1 && src_en) |=>
      state_r.cnt == $past(state_r.cnt) + 10'd1;
  endproperty
  a_no_sync: assert property (p_no_sync) else $error("count disturbed"); // [RULE_05]

  property p_ramp_sync;
    @(posedge clock) disable iff (!rst_n)
    (ph_en && sync_rise) |=> state_r.cnt == 10'd0;
  endproperty
  a_ramp_sync: assert property (p_ramp_sync) else $error("no ramp sync"); // [RULE_05]

  property p_half_src;
    @(posedge clock) disable iff (!rst_n)
    (half_src && $past(half_src)) |-> src_en != $past(src_en);
  endproperty
  a_half_src: assert property (p_half_src) else $error("source not halved"); // [RULE_06]

  property p_manual_div;
    @(posedge clock) disable iff (!rst_n)
    (wrap && manual && !tri_en && !rdm_en && state_r.manual_ramp_divider != 8'h00) |=>
      state_r.period == {2'b00, $past(state_r.manual_ramp_divider)};
  endproperty
  a_manual_div: assert property (p_manual_div) else $error("manual period"); // [RULE_10]

  property p_auto_div;
    @(posedge clock) disable iff (!rst_n)
    (wrap && !manual && !tri_en && !rdm_en) |=> state_r.period == {2'b00, rps_pkg::AUTO_DIV};
  endproperty
  a_auto_div: assert property (p_auto_div) else $error("auto period"); // [RULE_13]

  property p_rdm_span;
    @(posedge clock) disable iff (!rst_n)
    (wrap && rdm_en && !tri_en) |=>
      state_r.period - {2'b00, $past(base)} <= {2'b00, $past(span_mask)};
  endproperty
  a_rdm_span: assert property (p_rdm_span) else $error("random span"); // [RULE_08]

  property p_tri_bound;
    @(posedge clock) disable iff (!rst_n)
    wrap |=> state_r.tri_off <= $past(limit);
  endproperty
  a_tri_bound: assert property (p_tri_bound) else $error("triangle bound"); // [RULE_09]

  property p_fall_step;
    @(posedge clock) disable iff (!rst_n)
    (wrap && manual && tri_en && !state_r.tri_down && tri_up_sum < {1'b0, limit}) |=>
      state_r.tri_off == $past(state_r.tri_off) + $past(fall_step);
  endproperty
  a_fall_step: assert property (p_fall_step) else $error("fall step"); // [RULE_11]

  property p_rise_step;
    @(posedge clock) disable iff (!rst_n)
    (wrap && manual && tri_en && state_r.tri_down && state_r.tri_off > rise_step) |=>
      state_r.tri_off == $past(state_r.tri_off) - $past(rise_step);
  endproperty
  a_rise_step: assert property (p_rise_step) else $error("rise step"); // [RULE_12]

  c_tick: cover property (@(posedge clock) disable iff (!rst_n) ramp_tick && phase_sel == 2'd3);
  c_frame: cover property (@(posedge clock) disable iff (!rst_n) i2s_en && frame_rise);
  c_manual: cover property (@(posedge clock) disable iff (!rst_n) wrap && half_src && tri_en);
  c_turn: cover property (@(posedge clock) disable iff (!rst_n) $rose(state_r.tri_down));

endmodule : rps_ramp_ctrl

//--- sim/rps_ramp_ctrl_tb.sv
// Self-checking testbench for the ramp phase and spread-spectrum control block.
// Assumes a 100 MHz clock, registers reached through the strobed register port.
module rps_ramp_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic i2s_frame_pin = 1'b0;
  logic ramp_sync_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic ramp_tick;
  logic [9:0] ramp_period;
  int errors = 0;
  int check_count = 0;

  rps_ramp_ctrl uut (
    .clock(clock),
    .rst_n(rst_n),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .i2s_frame_pin(i2s_frame_pin),
    .ramp_sync_pin(ramp_sync_pin),
    .ramp_tick(ramp_tick),
    .ramp_period(ramp_period)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Strobe drops for one edge so back-to-back calls never re-assign it in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clock);
    #1 reg_wr_en = 1'b0;
    @(posedge clock);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1 reg_rd_en = 1'b0;
    d = reg_rdata;
    @(posedge clock);
    #1;
  endtask : rd

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (ramp_tick !== 1'b1 && n < 3000);
    if (n >= 3000) errors++;
  endtask : wait_tick

  task automatic spacing(output int s);
    int d;
    wait_tick(d);
    wait_tick(s);
  endtask : spacing

  // Raises one sync pin and counts edges up to the next ramp tick
  task automatic pin_delay(input int which, output int n);
    n = 0;
    if (which == 0) ramp_sync_pin = 1'b1;
    else i2s_frame_pin = 1'b1;
    do begin
      @(posedge clock);
      #1 n++;
      if (n == 8) begin
        ramp_sync_pin = 1'b0;
        i2s_frame_pin = 1'b0;
      end
    end while (ramp_tick !== 1'b1 && n < 3000);
    if (n < 8) begin
      ramp_sync_pin = 1'b0;
      i2s_frame_pin = 1'b0;
    end
  endtask : pin_delay

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] a [5];
    logic [7:0] r [5];
    logic [7:0] d;
    a = '{rps_pkg::ADDR_PHASE, rps_pkg::ADDR_DITHER, rps_pkg::ADDR_RANGE,
          rps_pkg::ADDR_DIV, rps_pkg::ADDR_STEP};
    r = '{rps_pkg::RST_PHASE, rps_pkg::RST_DITHER, rps_pkg::RST_RANGE,
          rps_pkg::RST_DIV, rps_pkg::RST_STEP};
    check(ramp_period, 16'h0050);
    for (int i = 0; i < 5; i++) begin
      rd(a[i], d);
      check(d, r[i]);
      wr(a[i], 8'ha5 ^ 8'(i));
      rd(a[i], d);
      check(d, 8'ha5 ^ 8'(i));
      wr(a[i], r[i]);
    end
    wr(8'h6f, 8'hff);
    rd(8'h6f, d);
    check(d, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_divisor();
    int s;
    wr(rps_pkg::ADDR_DIV, 8'h40);
    wr(rps_pkg::ADDR_DITHER, 8'h10);
    spacing(s);
    spacing(s);
    check(16'(s), 16'h0040);
    check(ramp_period, 16'h0040);
    wr(rps_pkg::ADDR_DITHER, 8'h30);
    spacing(s);
    spacing(s);
    check(16'(s), 16'h0080);
    wr(rps_pkg::ADDR_DITHER, 8'h20);
    spacing(s);
    spacing(s);
    check(16'(s), 16'h0050);
    wr(rps_pkg::ADDR_DITHER, 8'h00);
    $display("test divisor done");
  endtask : t_divisor

  // Ramp of 0x40 source ticks, so each phase step is 0x10, a quarter of the ramp
  task automatic t_phase();
    int d;
    int n;
    int dl [4];
    wr(rps_pkg::ADDR_DIV, 8'h40);
    wr(rps_pkg::ADDR_DITHER, 8'h10);
    for (int p = 0; p < 2; p++) begin
      wr(rps_pkg::ADDR_PHASE, 8'h0c);
      spacing(d);
      repeat (2) @(posedge clock);
      #1 pin_delay(p, n);
      check(16'(n), 16'd62);
      for (int sel = 0; sel < 4; sel++) begin
        wr(rps_pkg::ADDR_PHASE, 8'((sel << 2) | (p == 0 ? 1 : 2)));
        spacing(d);
        repeat (2) @(posedge clock);
        #1 pin_delay(p, dl[sel]);
        check(16'(dl[sel] - dl[0]), 16'(sel * 16));
      end
      wr(rps_pkg::ADDR_PHASE, 8'h01 << p);
      spacing(d);
      repeat (4) @(posedge clock);
      #1 pin_delay(p, n);
      check(16'(n), 16'(dl[0]));
    end
    wr(rps_pkg::ADDR_PHASE, 8'h00);
    wr(rps_pkg::ADDR_DITHER, 8'h00);
    $display("test phase done");
  endtask : t_phase

  // Periods must walk between base and base+lim only by the two step sizes
  task automatic t_tri(input logic [9:0] base, input logic [9:0] up,
                       input logic [9:0] dn, input logic [9:0] lim);
    int d;
    logic [9:0] p;
    logic [9:0] q;
    logic [9:0] mx;
    logic [9:0] mn;
    logic ok;
    wait_tick(d);
    q = ramp_period;
    mx = q;
    mn = q;
    ok = 1'b1;
    repeat (30) begin
      wait_tick(d);
      p = ramp_period;
      if (!(p == q || p == q + dn || p + up == q || p == base + lim || p == base)) ok = 1'b0;
      if (p > mx) mx = p;
      if (p < mn) mn = p;
      q = p;
    end
    check(mx, base + lim);
    check(mn, base);
    check(ok, 1'b1);
  endtask : t_tri

  task automatic t_dither();
    wr(rps_pkg::ADDR_DIV, 8'h20);
    wr(rps_pkg::ADDR_STEP, 8'h23);
    wr(rps_pkg::ADDR_DITHER, 8'h11);
    t_tri(10'h020, 10'h003, 10'h002, 10'h010);
    wr(rps_pkg::ADDR_DITHER, 8'h00);
    wr(rps_pkg::ADDR_STEP, 8'h88);
    wr(rps_pkg::ADDR_RANGE, 8'h04);
    wr(rps_pkg::ADDR_DITHER, 8'h21);
    t_tri(10'h050, 10'h001, 10'h001, 10'h004);
    wr(rps_pkg::ADDR_DITHER, 8'h00);
    $display("test triangle done");
  endtask : t_dither

  task automatic t_rand();
    int d;
    logic inr;
    logic chg;
    logic [9:0] first;
    wr(rps_pkg::ADDR_RANGE, 8'h30);
    wr(rps_pkg::ADDR_DITHER, 8'h02);
    spacing(d);
    first = ramp_period;
    inr = 1'b1;
    chg = 1'b0;
    repeat (20) begin
      wait_tick(d);
      if (ramp_period < 10'h050 || ramp_period > 10'h057) inr = 1'b0;
      if (ramp_period != first) chg = 1'b1;
    end
    check(inr, 1'b1);
    check(chg, 1'b1);
    wr(rps_pkg::ADDR_RANGE, 8'h00);
    spacing(d);
    repeat (8) begin
      wait_tick(d);
      check(ramp_period, 16'h0050);
    end
    wr(rps_pkg::ADDR_DITHER, 8'h00);
    $display("test random done");
  endtask : t_rand

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    t_regs();
    t_divisor();
    t_phase();
    t_dither();
    t_rand();
    finish_test();
  end

  // Whole run needs well under 20000 cycles; this allows 50000
  initial begin
    #500000;
    errors++;
    finish_test();
  end

endmodule : rps_ramp_ctrl_tb
